// *** hdl/input_supply_monitor_regs.sv ***
// Input supply monitor register page: event flag, mask, supply-good status,
// comparator sense bits, front LDO control and minimum system voltage.
// Assumes a serial control port slave on clock_i drives the access strobes,
// and that rst_n_i is the core-digital supply reset.
`timescale 1ns/1ps
module input_supply_monitor_regs
   import supply_monitor_pkg::*;
#(
   parameter int DB_100US_CYCLES = DB_100US_CYC,
   parameter int DB_1MS_CYCLES   = DB_1MS_CYC,
   parameter int DB_10MS_CYCLES  = DB_10MS_CYC
)(
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   // Register access from the serial control port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // Analog comparators, asynchronous levels
   input  wire logic       undervoltage_cmp_i,
   input  wire logic       input_system_low_cmp_i,
   input  wire logic       overvoltage_cmp_i,
   // Fuse values
   input  wire logic [1:0] otp_front_ldo_i,
   // Controls and status
   output logic            irq_o,
   output logic            supply_good_o,
   output logic            front_ldo_en_o,
   output logic      [1:0] min_system_voltage_sel_o,
   output logic            input_system_offset_sel_o
);
   // ------------------------------------------------------------------
   // Comparator sensing
   // ------------------------------------------------------------------
   logic [2:0] cmp_sync;
   debounce_if sys_db ();

   sync_stage #(
      .WIDTH   (3),
      .RST_VAL (CMP_RST)
   ) u_cmp_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .async_i ({overvoltage_cmp_i, input_system_low_cmp_i, undervoltage_cmp_i}),
      .sync_o  (cmp_sync)
   );

   debounce_filter u_sys_db (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .db      (sys_db.filt)
   );

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [7:0] event_flags;
   logic [7:0] event_mask;
   logic [7:0] ldo_oper;
   logic [7:0] ldo_reg;
   logic [7:0] sys_cfg;
   logic       undervoltage_sense;
   logic       input_above_system_sense;
   logic       overvoltage_sense;
   logic       input_valid;
   logic       otp_pending;
   logic [7:0] next_event_flags;
   logic [7:0] next_event_mask;
   logic [7:0] next_ldo_oper;
   logic [7:0] next_ldo_reg;
   logic [7:0] next_sys_cfg;
   logic       next_undervoltage_sense;
   logic       next_input_above_system_sense;
   logic       next_overvoltage_sense;
   logic       next_input_valid;
   logic       next_supply_good;
   logic       next_otp_pending;
   logic [7:0] next_rdata;
   logic       next_irq;
   logic [7:0] sense_word;
   logic [7:0] status_word;
   logic       supply_event;

   // Debounce time follows the host selection; the reserved code uses the shortest
   always_comb
   begin
      sys_db.raw = cmp_sync[1];
      case (debounce_sel_t'(sys_cfg[1:0]))
         DB_1MS:  sys_db.limit = DB_CNT_W'(DB_1MS_CYCLES);
         DB_10MS: sys_db.limit = DB_CNT_W'(DB_10MS_CYCLES);
         default: sys_db.limit = DB_CNT_W'(DB_100US_CYCLES);
      endcase
   end

   always_comb
   begin
      next_undervoltage_sense       = cmp_sync[0];
      next_input_above_system_sense = sys_db.stable;
      next_overvoltage_sense        = cmp_sync[2];
      next_input_valid = !next_undervoltage_sense && !next_input_above_system_sense
                         && !next_overvoltage_sense;
      next_supply_good = next_input_valid;
      supply_event     = next_supply_good != supply_good_o;

      sense_word            = 8'h00;
      sense_word[BIT_UV]    = undervoltage_sense;
      sense_word[BIT_SYS]   = input_above_system_sense;
      sense_word[BIT_OV]    = overvoltage_sense;
      sense_word[BIT_VALID] = input_valid;
      status_word           = STATUS_FIXED;
      status_word[BIT_EVENT] = supply_good_o;
   end

   // ------------------------------------------------------------------
   // Host writes, event capture and fuse load
   // ------------------------------------------------------------------
   always_comb
   begin
      next_event_flags = event_flags;
      next_event_mask  = event_mask;
      next_ldo_oper    = ldo_oper;
      next_ldo_reg     = ldo_reg;
      next_sys_cfg     = sys_cfg;
      next_otp_pending = 1'b0;
      if (reg_wr_i && !otp_pending)
      begin
         if (reg_addr_i == ADDR_FLAGS)
         begin
            next_event_flags = reg_wdata_i;
            next_event_flags[BIT_EVENT] = event_flags[BIT_EVENT]
                                          && !reg_wdata_i[BIT_EVENT];
         end
         else if (reg_addr_i == ADDR_MASK)
         begin
            next_event_mask = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_LDO_OPER)
         begin
            next_ldo_oper = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_LDO_REG)
         begin
            next_ldo_reg = reg_wdata_i;
         end
         else if (reg_addr_i == ADDR_SYS_CFG)
         begin
            next_sys_cfg = reg_wdata_i;
         end
      end
      // Fuse value lands in the first cycle after reset release
      if (otp_pending)
      begin
         next_ldo_oper[1:0] = otp_front_ldo_i;
      end
      // A new event wins over a clear in the same cycle
      if (supply_event)
      begin
         next_event_flags[BIT_EVENT] = 1'b1;
      end
      next_irq = next_event_flags[BIT_EVENT] && !next_event_mask[BIT_EVENT];
   end

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   always_comb
   begin
      next_rdata = reg_rdata_o;
      if (reg_rd_i)
      begin
         if (reg_addr_i == ADDR_FLAGS)
         begin
            next_rdata = event_flags;
         end
         else if (reg_addr_i == ADDR_MASK)
         begin
            next_rdata = event_mask;
         end
         else if (reg_addr_i == ADDR_STATUS)
         begin
            next_rdata = status_word;
         end
         else if (reg_addr_i == ADDR_SENSE)
         begin
            next_rdata = sense_word;
         end
         else if (reg_addr_i == ADDR_LDO_OPER)
         begin
            next_rdata = ldo_oper;
         end
         else if (reg_addr_i == ADDR_LDO_REG)
         begin
            next_rdata = ldo_reg;
         end
         else if (reg_addr_i == ADDR_SYS_CFG)
         begin
            next_rdata = sys_cfg;
         end
         else
         begin
            next_rdata = UNMAPPED_RD;
         end
      end
   end

   // ------------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------------
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         event_flags               <= FLAGS_RST;
         event_mask                <= MASK_RST;
         ldo_oper                  <= LDO_OPER_RST;
         ldo_reg                   <= LDO_REG_RST;
         sys_cfg                   <= SYS_CFG_RST;
         undervoltage_sense        <= CMP_RST[0];
         input_above_system_sense  <= CMP_RST[1];
         overvoltage_sense         <= CMP_RST[2];
         input_valid               <= 1'b0;
         otp_pending               <= 1'b1;
         supply_good_o             <= 1'b0;
         irq_o                     <= 1'b0;
         reg_rdata_o               <= 8'h00;
         front_ldo_en_o            <= 1'b0;
         min_system_voltage_sel_o  <= 2'h0;
         input_system_offset_sel_o <= 1'b0;
      end
      else
      begin
         event_flags               <= next_event_flags;
         event_mask                <= next_event_mask;
         ldo_oper                  <= next_ldo_oper;
         ldo_reg                   <= next_ldo_reg;
         sys_cfg                   <= next_sys_cfg;
         undervoltage_sense        <= next_undervoltage_sense;
         input_above_system_sense  <= next_input_above_system_sense;
         overvoltage_sense         <= next_overvoltage_sense;
         input_valid               <= next_input_valid;
         otp_pending               <= next_otp_pending;
         supply_good_o             <= next_supply_good;
         irq_o                     <= next_irq;
         reg_rdata_o               <= next_rdata;
         front_ldo_en_o            <= next_ldo_oper[1:0] == LDO_ON_CODE;
         min_system_voltage_sel_o  <= next_ldo_reg[MIN_SYSTEM_VOLTAGE_SEL_LSB +: 2];
         input_system_offset_sel_o <= next_sys_cfg[OFFSET_SEL_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   property p_flag_on_change;
      (supply_good_o != $past(supply_good_o)) |-> event_flags[BIT_EVENT];
   endproperty
   a_flag_on_change: assert property (p_flag_on_change)
      else $error("supply-good change did not set the event flag");

   property p_flag_clear;
      (reg_wr_i && !otp_pending && reg_addr_i == ADDR_FLAGS && reg_wdata_i[BIT_EVENT]
       && next_supply_good == supply_good_o) |=> !event_flags[BIT_EVENT];
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("event flag survived a clear");

   property p_mask_write;
      (reg_wr_i && !otp_pending && reg_addr_i == ADDR_MASK)
      |=> event_mask == $past(reg_wdata_i);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("mask write not stored");

   property p_irq;
      irq_o == (event_flags[BIT_EVENT] && !event_mask[BIT_EVENT]);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt request disagrees with flag and mask");

   property p_status_tracks;
      status_word[BIT_EVENT] == input_valid;
   endproperty
   a_status_tracks: assert property (p_status_tracks)
      else $error("status bit differs from input valid");

   property p_valid;
      input_valid == (!undervoltage_sense && !input_above_system_sense
                      && !overvoltage_sense);
   endproperty
   a_valid: assert property (p_valid)
      else $error("input valid disagrees with the sense bits");

   property p_uv_ov_follow;
      ##1 (undervoltage_sense == $past(cmp_sync[0], 1))
          && (overvoltage_sense == $past(cmp_sync[2], 1));
   endproperty
   a_uv_ov_follow: assert property (p_uv_ov_follow)
      else $error("sense bits lag their comparators");

   // Outputs sit low in reset while the field holds its default, so the
   // check starts one edge after reset has been seen released
   property p_ldo_en;
      $past(rst_n_i) |-> (front_ldo_en_o == (ldo_oper[1:0] == LDO_ON_CODE));
   endproperty
   a_ldo_en: assert property (p_ldo_en)
      else $error("front LDO enable disagrees with its field");

   property p_otp_load;
      (otp_pending && rst_n_i) |=> ldo_oper[1:0] == $past(otp_front_ldo_i);
   endproperty
   a_otp_load: assert property (p_otp_load)
      else $error("fuse value not loaded after reset");

   property p_unmapped;
      (reg_rd_i && reg_addr_i < PAGE_BASE) |=> reg_rdata_o == UNMAPPED_RD;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("read below the page base returned data");

   c_event: cover property (!event_flags[BIT_EVENT] ##1 event_flags[BIT_EVENT]);
   c_irq: cover property (!irq_o ##1 irq_o);
   c_clear: cover property (event_flags[BIT_EVENT] ##1 !event_flags[BIT_EVENT]);
   c_valid: cover property (!input_valid ##1 input_valid);
endmodule

// *** hdl/supply_monitor_pkg.sv ***
// Constants for the input supply monitor register page: addresses, fields,
// reset values and debounce timing.
// Assumes a 200 MHz core clock.
package supply_monitor_pkg;

   // ------------------------------------------------------------------
   // Register addresses
   // ------------------------------------------------------------------
   localparam logic [7:0] PAGE_BASE    = 8'h80;
   localparam logic [7:0] OFF_FLAGS    = 8'h00;
   localparam logic [7:0] OFF_MASK     = 8'h02;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_SENSE    = 8'h06;
   localparam logic [7:0] OFF_LDO_OPER = 8'h09;
   localparam logic [7:0] OFF_LDO_REG  = 8'h0f;
   localparam logic [7:0] OFF_SYS_CFG  = 8'h1b;
   localparam logic [7:0] ADDR_FLAGS    = PAGE_BASE + OFF_FLAGS;
   localparam logic [7:0] ADDR_MASK     = PAGE_BASE + OFF_MASK;
   localparam logic [7:0] ADDR_STATUS   = PAGE_BASE + OFF_STATUS;
   localparam logic [7:0] ADDR_SENSE    = PAGE_BASE + OFF_SENSE;
   localparam logic [7:0] ADDR_LDO_OPER = PAGE_BASE + OFF_LDO_OPER;
   localparam logic [7:0] ADDR_LDO_REG  = PAGE_BASE + OFF_LDO_REG;
   localparam logic [7:0] ADDR_SYS_CFG  = PAGE_BASE + OFF_SYS_CFG;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int BIT_EVENT      = 5;
   localparam int BIT_UV         = 2;
   localparam int BIT_SYS        = 3;
   localparam int BIT_OV         = 4;
   localparam int BIT_VALID      = 5;
   localparam int MIN_SYSTEM_VOLTAGE_SEL_LSB    = 6;
   localparam int OFFSET_SEL_BIT = 2;

   // ------------------------------------------------------------------
   // Reset values and codes
   // ------------------------------------------------------------------
   localparam logic [7:0] FLAGS_RST    = 8'h00;
   localparam logic [7:0] MASK_RST     = 8'hff;
   localparam logic [7:0] STATUS_FIXED = 8'h84;
   localparam logic [7:0] LDO_OPER_RST = 8'h01;
   localparam logic [7:0] LDO_REG_RST  = 8'h2b;
   localparam logic [7:0] SYS_CFG_RST  = 8'h00;
   localparam logic [7:0] UNMAPPED_RD  = 8'h00;
   localparam logic [1:0] LDO_ON_CODE  = 2'h1;
   localparam logic [2:0] CMP_RST      = 3'h3;   // {over, system low, under}
   localparam logic       SYS_LOW_RST  = 1'h1;

   typedef enum logic [1:0]
   {
      DB_RESERVED = 2'b00,
      DB_100US    = 2'b01,
      DB_1MS      = 2'b10,
      DB_10MS     = 2'b11
   } debounce_sel_t;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int DB_100US_NS   = 100_000;
   localparam int DB_1MS_NS     = 1_000_000;
   localparam int DB_10MS_NS    = 10_000_000;
   localparam int DB_100US_CYC  = DB_100US_NS / CLK_PERIOD_NS;
   localparam int DB_1MS_CYC    = DB_1MS_NS / CLK_PERIOD_NS;
   localparam int DB_10MS_CYC   = DB_10MS_NS / CLK_PERIOD_NS;
   localparam int DB_CNT_W      = 21;

endpackage

// *** hdl/debounce_if.sv ***
// Carrier between the register page and its comparator debounce filter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface debounce_if;
   import supply_monitor_pkg::*;
   logic                raw;
   logic [DB_CNT_W-1:0] limit;
   logic                stable;
   modport filt (input raw, input limit, output stable);
   modport user (output raw, output limit, input stable);
endinterface

// *** hdl/sync_stage.sv ***
// Two-flop synchroniser for a group of asynchronous comparator levels.
// Assumes the inputs are quasi-static levels, no multi-bit coherence needed.
`timescale 1ns/1ps
module sync_stage #(
   parameter int         WIDTH   = 1,
   parameter logic [2:0] RST_VAL = 3'h0
)(
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   // Levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_sync;

   always_comb
   begin
      next_meta = async_i;
      next_sync = meta;
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta   <= RST_VAL[WIDTH-1:0];
         sync_o <= RST_VAL[WIDTH-1:0];
      end
      else
      begin
         meta   <= next_meta;
         sync_o <= next_sync;
      end
   end
endmodule

// *** hdl/debounce_filter.sv ***
// Debounce filter: the output follows the input only after the input has
// held a new level for the selected number of cycles.
// Assumes the input is already synchronised to clock_i.
`timescale 1ns/1ps
module debounce_filter
   import supply_monitor_pkg::*;
(
   // Clock and reset
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   // Filter channel
   debounce_if.filt  db
);
   logic [DB_CNT_W-1:0] count;
   logic [DB_CNT_W-1:0] next_count;
   logic                next_stable;

   always_comb
   begin
      next_count  = '0;
      next_stable = db.stable;
      if (db.raw != db.stable)
      begin
         if (count + 1'b1 >= db.limit)
         begin
            next_stable = db.raw;
         end
         else
         begin
            next_count = count + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count     <= '0;
         db.stable <= SYS_LOW_RST;
      end
      else
      begin
         count     <= next_count;
         db.stable <= next_stable;
      end
   end

   property p_db_hold;
      @(posedge clock_i) disable iff (!rst_n_i)
      (db.stable != $past(db.stable)) |-> ($past(count) + 1 >= $past(db.limit));
   endproperty
   a_db_hold: assert property (p_db_hold)
      else $error("debounced level changed before the hold time");
endmodule

// *** bench/front_end_model.sv ***
// Behavioural analog front end: turns supply levels into comparator outputs.
// Assumes levels in millivolts; thresholds are plain defaults, not real trims.
`timescale 1ns/1ps
module front_end_model #(
   parameter int UV_MV = 3000,
   parameter int OV_MV = 6000
)(
   // Supply levels
   input  wire logic [15:0] vin_mv_i,
   input  wire logic [15:0] vsys_mv_i,
   input  wire logic        offset_sel_i,
   // Comparator levels
   output logic             uv_o,
   output logic             sys_low_o,
   output logic             ov_o
);
   // Detached input reads as zero, so it lands below every threshold
   assign uv_o      = (vin_mv_i < UV_MV);
   assign sys_low_o = (vin_mv_i < vsys_mv_i + (offset_sel_i ? 175 : 50));
   assign ov_o      = (vin_mv_i > OV_MV);
endmodule

// *** bench/input_supply_monitor_regs_bench.sv ***
// Self-checking bench for the supply monitor page, host side by tasks.
// Assumes the front end model and short debounce counts.
`timescale 1ns/1ps
module input_supply_monitor_regs_bench;
   import supply_monitor_pkg::*;
   logic clock_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, uv, sl, ov;
   logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
   logic [1:0] otp = 0, vsel;
   logic [15:0] vin = 0, vsys = 16'd3700;
   logic irq, good, ldo_en, osel;
   int miscompares = 0, check_count = 0;
   always #2.5 clock_i = ~clock_i;
   front_end_model fe (.vin_mv_i(vin), .vsys_mv_i(vsys), .offset_sel_i(osel),
      .uv_o(uv), .sys_low_o(sl), .ov_o(ov));
   input_supply_monitor_regs #(.DB_100US_CYCLES(4), .DB_1MS_CYCLES(8),
      .DB_10MS_CYCLES(16)) dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .undervoltage_cmp_i(uv),
      .input_system_low_cmp_i(sl), .overvoltage_cmp_i(ov), .otp_front_ldo_i(otp),
      .irq_o(irq), .supply_good_o(good), .front_ldo_en_o(ldo_en),
      .min_system_voltage_sel_o(vsel), .input_system_offset_sel_o(osel));
   // ------------------------------------------------------------------
   // Host tasks
   // ------------------------------------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, e);
   endtask
   task automatic wait_good(input logic v);
      int n;
      for (n = 0; n < 200 && good !== v; n++)
         @(posedge clock_i);
      if (good !== v)
      begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic do_reset();
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clock_i);
   endtask
   task automatic defaults(input logic [7:0] ldo);
      rd(ADDR_FLAGS, 8'h00);
      rd(ADDR_MASK, 8'hff);
      rd(ADDR_STATUS, 8'h84);
      rd(ADDR_SENSE, 8'h0c);
      rd(ADDR_LDO_OPER, ldo);
      rd(ADDR_LDO_REG, 8'h2b);
      rd(8'h81, 8'h00);
      rd(OFF_SENSE, 8'h00);
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   initial
   begin
      do_reset();
      defaults(8'h00);
      vin <= 16'd5000;
      wait_good(1'b1);
      rd(ADDR_SENSE, 8'h20);
      rd(ADDR_STATUS, 8'ha4);
      rd(ADDR_FLAGS, 8'h20);
      chk(irq, 8'h00);
      wr(ADDR_MASK, 8'hdf);
      chk(irq, 8'h01);
      wr(ADDR_FLAGS, 8'h20);
      rd(ADDR_FLAGS, 8'h00);
      chk(irq, 8'h00);
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, 8'ha4);
      vin <= 16'd6500;
      wait_good(1'b0);
      rd(ADDR_SENSE, 8'h10);
      rd(ADDR_FLAGS, 8'h20);
      chk(irq, 8'h01);
      vin <= 16'd3800;
      wait_good(1'b1);
      wr(ADDR_SYS_CFG, 8'h04);
      chk(osel, 8'h01);
      wait_good(1'b0);
      rd(ADDR_SENSE, 8'h08);
      // Longest debounce: 2 sync edges, 16 filter edges, 1 sense edge
      wr(ADDR_SYS_CFG, 8'h07);
      vin <= 16'd3900;
      repeat (18) @(posedge clock_i);
      #1;
      chk(good, 8'h00);
      @(posedge clock_i);
      #1;
      chk(good, 8'h01);
      // Middle debounce: 2 sync edges, 8 filter edges, 1 sense edge
      wr(ADDR_SYS_CFG, 8'h06);
      vin <= 16'd3800;
      repeat (10) @(posedge clock_i);
      #1;
      chk(good, 8'h01);
      @(posedge clock_i);
      #1;
      chk(good, 8'h00);
      wr(ADDR_LDO_OPER, 8'h01);
      chk(ldo_en, 8'h01);
      rd(ADDR_LDO_OPER, 8'h01);
      wr(ADDR_LDO_OPER, 8'h00);
      chk(ldo_en, 8'h00);
      for (int i = 0; i < 3; i++)
      begin
         wr(ADDR_LDO_REG, {i[1:0], 6'h2b});
         chk(vsel, i[7:0]);
      end
      otp <= 2'h1;
      vin <= 16'd0;
      do_reset();
      defaults(8'h01);
      chk(osel, 8'h00);
      conclude();
   end
endmodule
